// *** pkg/sgp_pkg.sv ***
// constants for the six pin general purpose port
package sgp_pkg;
  localparam int PIN_W = 6;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SHARED_PIN = 3;
  localparam logic [3:0] OFS_PIN_LEVEL = 4'h0;
  localparam logic [3:0] OFS_DIRECTION = 4'h1;
  localparam logic [3:0] OFS_OUT_LATCH = 4'h2;
  localparam logic [3:0] OFS_ANALOG = 4'h3;
  localparam logic [3:0] OFS_PULL_UP = 4'h4;
  localparam logic [3:0] OFS_OPEN_DRAIN = 4'h5;
  localparam logic [3:0] OFS_SLEW = 4'h6;
  localparam logic [3:0] OFS_THRESHOLD = 4'h7;
  localparam logic [5:0] RST_LATCH = 6'h00;
  localparam logic [5:0] RST_DIRECTION = 6'h3F;
  localparam logic [5:0] RST_ANALOG = 6'h3F;
  localparam logic [5:0] RST_PULL_UP = 6'h00;
  localparam logic [5:0] RST_OPEN_DRAIN = 6'h00;
  localparam logic [5:0] RST_SLEW = 6'h3F;
  localparam logic [5:0] RST_THRESHOLD = 6'h3F;
  localparam logic [5:0] SHARED_MASK = 6'h08;
  localparam logic [5:0] LATCH_MASK = 6'h37;
  localparam logic [5:0] ODRAIN_MASK = 6'h37;
endpackage

// *** pkg/sgp_sync_if.sv ***
// synchroniser carrier between port core and input stage
`timescale 1ns/100ps
interface sgp_sync_if;
  logic [5:0] raw;
  logic [5:0] synced;
  modport core (output raw, input synced);
  modport stage (input raw, output synced);
endinterface

// *** src/sgp_port.sv ***
// six pin general purpose port: registers, pin drive and read path
`timescale 1ns/100ps
module sgp_port #(
  parameter int PINS = sgp_pkg::PIN_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [sgp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sgp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sgp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [sgp_pkg::PIN_W-1:0] pin_st_in,
  input wire logic [sgp_pkg::PIN_W-1:0] pin_ttl_in,
  output logic [sgp_pkg::PIN_W-1:0] pin_out,
  output logic [sgp_pkg::PIN_W-1:0] pin_oe,
  output logic [sgp_pkg::PIN_W-1:0] pin_pull_up,
  output logic [sgp_pkg::PIN_W-1:0] pin_slew_limit,
  output logic [sgp_pkg::PIN_W-1:0] pin_digital_in_en,
  output logic [sgp_pkg::PIN_W-1:0] pin_change_level,
  input wire logic [sgp_pkg::PIN_W-1:0] periph_sel,
  input wire logic [sgp_pkg::PIN_W-1:0] periph_out,
  input wire logic [sgp_pkg::PIN_W-1:0] periph_oe,
  input wire logic [sgp_pkg::PIN_W-1:0] i2c_own,
  input wire logic [sgp_pkg::PIN_W-1:0] analog_out_en,
  input wire logic external_reset_enable
);
  import sgp_pkg::*;

  // edges seen since reset, for the synchroniser check
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  typedef struct packed {
    logic [1:0] warm;
    logic [5:0] latch;
    logic [5:0] direction;
    logic [5:0] analog;
    logic [5:0] pull_up;
    logic [5:0] open_drain;
    logic [5:0] slew;
    logic [5:0] threshold;
    logic [7:0] rdata;
  } sgp_state_t;

  sgp_state_t state;
  sgp_state_t next_state;

  sgp_sync_if sif ();
  logic [5:0] pin_level;
  logic [5:0] digital_read;
  logic [5:0] pin_read;
  logic [5:0] src_out;
  logic [5:0] src_oe;
  logic [5:0] odrain;
  logic [5:0] drive_oe;
  logic [5:0] drive_out;
  logic [5:0] drive_pu;
  logic [5:0] next_rdval;

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // threshold choice per pin
      assign sif.raw[g] = state.threshold[g] ? pin_st_in[g] : pin_ttl_in[g];
      assign pin_change_level[g] = sif.raw[g];
    end
  endgenerate

  sgp_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .sif(sif)
  );

  assign pin_level = sif.synced;
  // analog pins read as zero
  assign digital_read = pin_level & ~state.analog;
  // shared pin forced high while it serves as reset
  assign pin_read = external_reset_enable ? (digital_read | SHARED_MASK) : digital_read;

  always_comb begin
    // latch by default; peripheral only when selected
    src_out = (periph_sel & periph_out) | (~periph_sel & state.latch);
    src_oe = (periph_sel & periph_oe) | (~periph_sel & ~state.direction);
    odrain = state.open_drain | i2c_own;
    drive_oe = src_oe & ~(odrain & src_out) & ~analog_out_en & ~SHARED_MASK;
    drive_out = src_out & ~odrain;
    drive_pu = (state.pull_up & ~src_oe) | (external_reset_enable ? SHARED_MASK : 6'h00);
  end

  assign pin_out = drive_out;
  assign pin_oe = drive_oe;
  assign pin_pull_up = drive_pu;
  assign pin_slew_limit = state.slew;
  assign pin_digital_in_en = ~state.analog;
  assign reg_rdata = state.rdata;

  always_comb begin
    next_state = state;
    next_state.rdata = 8'h00;
    if (state.warm != SYNC_STAGES) begin
      next_state.warm = state.warm + 2'h1;
    end
    if (reg_wr) begin
      case (reg_addr)
        OFS_PIN_LEVEL, OFS_OUT_LATCH: begin
          // byte write replaces every latch bit; pins read first
          // shared bit has no latch cell, so it is dropped after the merge
          next_state.latch = ((pin_read & ~LATCH_MASK) | (reg_wdata[5:0] & LATCH_MASK))
            & LATCH_MASK;
        end
        OFS_DIRECTION: next_state.direction = reg_wdata[5:0] | SHARED_MASK;
        OFS_ANALOG: next_state.analog = reg_wdata[5:0] & LATCH_MASK;
        OFS_PULL_UP: next_state.pull_up = reg_wdata[5:0];
        OFS_OPEN_DRAIN: next_state.open_drain = reg_wdata[5:0] & ODRAIN_MASK;
        OFS_SLEW: next_state.slew = reg_wdata[5:0] & LATCH_MASK;
        OFS_THRESHOLD: next_state.threshold = reg_wdata[5:0];
        default: next_state.latch = state.latch;
      endcase
    end
    next_rdval = 6'h00;
    case (reg_addr)
      OFS_PIN_LEVEL: next_rdval = pin_read;
      OFS_OUT_LATCH: next_rdval = state.latch & LATCH_MASK;
      OFS_DIRECTION: next_rdval = state.direction | SHARED_MASK;
      OFS_ANALOG: next_rdval = state.analog;
      OFS_PULL_UP: next_rdval = state.pull_up;
      OFS_OPEN_DRAIN: next_rdval = state.open_drain;
      OFS_SLEW: next_rdval = state.slew;
      OFS_THRESHOLD: next_rdval = state.threshold;
      default: next_rdval = 6'h00;
    endcase
    if (reg_rd) begin
      next_state.rdata = {2'b00, next_rdval};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.warm <= 2'h0;
      state.latch <= RST_LATCH;
      state.direction <= RST_DIRECTION;
      state.analog <= RST_ANALOG & LATCH_MASK;
      state.pull_up <= RST_PULL_UP;
      state.open_drain <= RST_OPEN_DRAIN;
      state.slew <= RST_SLEW & LATCH_MASK;
      state.threshold <= RST_THRESHOLD;
      state.rdata <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // assertions
  sequence latch_write_s;
    reg_wr && (reg_addr == OFS_OUT_LATCH || reg_addr == OFS_PIN_LEVEL);
  endsequence

  latch_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    latch_write_s |=> (state.latch & LATCH_MASK) == ($past(reg_wdata[5:0]) & LATCH_MASK))
    else $error("latch not loaded by write");
  latch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_wr |=> state.latch == $past(state.latch))
    else $error("latch changed without write");
  analog_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == OFS_PIN_LEVEL && !external_reset_enable) |=>
      (reg_rdata[5:0] & $past(state.analog)) == 6'h00)
    else $error("analog pin read nonzero");
  shared_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == OFS_DIRECTION) |=> reg_rdata[SHARED_PIN] && pin_oe[SHARED_PIN] == 1'b0)
    else $error("shared pin direction wrong");
  analog_out_a: assert property (@(posedge clk) disable iff (!arst_n)
    (analog_out_en != 6'h00) |-> (pin_oe & analog_out_en) == 6'h00)
    else $error("driver on under analog output");
  pull_out_a: assert property (@(posedge clk) disable iff (!arst_n)
    ((pin_pull_up & ~periph_sel & ~state.direction & ~SHARED_MASK) == 6'h00))
    else $error("pull-up on output pin");
  shared_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == OFS_PIN_LEVEL && external_reset_enable) |=> reg_rdata[SHARED_PIN])
    else $error("shared pin read low under reset");
  sync_delay_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state.warm == SYNC_STAGES) |-> pin_level == $past(sif.raw, 2))
    else $error("pin level not two stages late");
  odrain_a: assert property (@(posedge clk) disable iff (!arst_n)
    ((state.open_drain | i2c_own) & pin_oe & pin_out) == 6'h00)
    else $error("open-drain pin sourcing");

  sequence latch_read_s;
    reg_rd && reg_addr == OFS_OUT_LATCH;
  endsequence

  latch_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    latch_read_s |=> reg_rdata[5:0] == ($past(state.latch) & LATCH_MASK))
    else $error("latch read wrong");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  rdata_top_a: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rdata[7:6] == 2'b00)
    else $error("upper read bits set");
  latch_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.latch[SHARED_PIN] == 1'b0)
    else $error("shared latch bit set");
  shared_oe_a: assert property (@(posedge clk) disable iff (!arst_n)
    pin_oe[SHARED_PIN] == 1'b0 && state.direction[SHARED_PIN])
    else $error("shared pin driven");
  input_drv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pin_oe & ~periph_sel & state.direction) == 6'h00)
    else $error("input pin driven");
  latch_src_a: assert property (@(posedge clk) disable iff (!arst_n)
    ((pin_out ^ state.latch) & ~periph_sel & ~(state.open_drain | i2c_own)) == 6'h00)
    else $error("pin not fed by latch");
  i2c_drain_a: assert property (@(posedge clk) disable iff (!arst_n)
    (i2c_own & pin_oe & pin_out) == 6'h00)
    else $error("i2c pin sourcing");
  slew_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    pin_slew_limit == state.slew)
    else $error("slew output wrong");
  din_en_a: assert property (@(posedge clk) disable iff (!arst_n)
    pin_digital_in_en == ~state.analog)
    else $error("input buffer enable wrong");
  thresh_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
    pin_change_level == ((state.threshold & pin_st_in) | (~state.threshold & pin_ttl_in)))
    else $error("threshold selection wrong");
  pull_shared_a: assert property (@(posedge clk) disable iff (!arst_n)
    external_reset_enable |-> pin_pull_up[SHARED_PIN])
    else $error("shared pull-up off under reset");
  pull_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!external_reset_enable && !state.pull_up[SHARED_PIN]) |-> !pin_pull_up[SHARED_PIN])
    else $error("shared pull-up on while off");
endmodule // sgp_port

// *** src/sgp_sync.sv ***
// two stage synchroniser for pin levels
`timescale 1ns/100ps
module sgp_sync (
  input wire logic clk,
  input wire logic arst_n,
  sgp_sync_if.stage sif
);
  import sgp_pkg::*;
  typedef struct packed {
    logic [5:0] first;
    logic [5:0] second;
  } sgp_sync_state_t;
  sgp_sync_state_t state;
  sgp_sync_state_t next_state;
  always_comb begin
    next_state.first = sif.raw;
    next_state.second = state.first;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign sif.synced = state.second;
endmodule // sgp_sync

// *** tb/sgp_pin_model.sv ***
// pad model turning drive, pull-up and ttl offset into comparator levels
`timescale 1ns/100ps
module sgp_pin_model (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pull_up,
  input wire logic [5:0] ttl_skew,
  output logic [5:0] pin_st_in,
  output logic [5:0] pin_ttl_in
);
  logic [5:0] last = 6'h00;
  logic [5:0] lvl;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) begin
        lvl[i] = pin_out[i];
      end else if (pin_pull_up[i]) begin
        lvl[i] = 1'b1;
      end else begin
        lvl[i] = ~last[i]; // undriven pad wanders
      end
    end
  end
  always_ff @(posedge clk) begin
    last <= lvl;
  end
  assign pin_st_in = lvl;
  assign pin_ttl_in = lvl ^ ttl_skew; // ttl sees a different level when commanded
endmodule // sgp_pin_model

// *** tb/sgp_port_bench.sv ***
// self-checking bench for the six pin port
`timescale 1ns/100ps
module sgp_port_bench;
  import sgp_pkg::*;
  logic clk, arst_n, reg_wr, reg_rd, ere;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [5:0] st, ttl, p_out, p_oe, p_pu, slew, din_en, chg;
  logic [5:0] psel, pout, poe, i2c, aout, skew;
  int errors, samples_checked;
  logic [7:0] rst_exp [0:8] = '{8'h08, 8'h3F, 8'h00, 8'h37, 8'h00, 8'h00, 8'h37, 8'h3F, 8'h00};
  sgp_port dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_st_in(st),
    .pin_ttl_in(ttl), .pin_out(p_out), .pin_oe(p_oe), .pin_pull_up(p_pu),
    .pin_slew_limit(slew), .pin_digital_in_en(din_en), .pin_change_level(chg),
    .periph_sel(psel), .periph_out(pout), .periph_oe(poe), .i2c_own(i2c),
    .analog_out_en(aout), .external_reset_enable(ere));
  sgp_pin_model pads (.clk(clk), .pin_out(p_out), .pin_oe(p_oe), .pin_pull_up(p_pu),
    .ttl_skew(skew), .pin_st_in(st), .pin_ttl_in(ttl));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    repeat (2) @(posedge clk); // let pad levels cross the synchroniser
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    {psel, pout, poe, i2c, aout, skew} = '0;
    ere = 1'b1;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i <= 8; i++) rd(i[3:0], rst_exp[i]);
    chk({2'b00, p_oe}, 8'h00);
    chk({2'b00, din_en}, 8'h08);
    chk({2'b00, slew}, 8'h37);
    wr(OFS_ANALOG, 8'h00);
    wr(OFS_PULL_UP, 8'h3F);
    chk({2'b00, p_pu}, 8'h3F);
    rd(OFS_PIN_LEVEL, 8'h3F);
    skew <= 6'h3F;
    wr(OFS_THRESHOLD, 8'h00);
    chk({2'b00, chg}, 8'h00);
    rd(OFS_PIN_LEVEL, 8'h08);
    wr(OFS_THRESHOLD, 8'h3F);
    chk({2'b00, chg}, 8'h3F);
    wr(OFS_DIRECTION, 8'h00);
    rd(OFS_DIRECTION, 8'h08);
    chk({2'b00, p_pu}, 8'h08);
    wr(OFS_OUT_LATCH, 8'h15);
    chk({2'b00, p_oe}, 8'h37);
    chk({2'b00, p_out}, 8'h15);
    rd(OFS_PIN_LEVEL, 8'h1D);
    wr(OFS_PIN_LEVEL, 8'h2B);
    rd(OFS_OUT_LATCH, 8'h23);
    wr(OFS_ANALOG, 8'h01);
    chk({2'b00, din_en}, 8'h3E);
    chk({2'b00, p_oe}, 8'h37);
    rd(OFS_PIN_LEVEL, 8'h2A);
    wr(OFS_OPEN_DRAIN, 8'h3F);
    chk({2'b00, p_oe}, 8'h14);
    chk({2'b00, p_out & p_oe}, 8'h00);
    wr(OFS_OPEN_DRAIN, 8'h00);
    @(posedge clk);
    i2c <= 6'h01;
    #1 chk({2'b00, p_oe}, 8'h36);
    @(posedge clk);
    aout <= 6'h3F;
    #1 chk({2'b00, p_oe}, 8'h00);
    @(posedge clk);
    {aout, psel, pout, poe} <= {6'h00, 6'h02, 6'h00, 6'h02};
    #1 chk({2'b00, p_out}, 8'h20);
    chk({2'b00, p_oe}, 8'h36);
    @(posedge clk);
    ere <= 1'b0;
    wr(OFS_PULL_UP, 8'h00);
    chk({2'b00, p_pu}, 8'h00);
    wr(OFS_SLEW, 8'h00);
    chk({2'b00, slew}, 8'h00);
    summarize;
  end
endmodule // sgp_port_bench
